// ==== logic/tw_core.sv ====
// two-wire bus controller: master engine, slave engine and line sampler
`timescale 1ns/1ps
`default_nettype none
`include "tw_map.svh"
module tw_core (
   // clocks and reset
   input  wire logic            core_clk,
   input  wire logic            rst,
   input  wire logic            linkClk,
   // bus pins
   input  wire tw_pkg::tw_pin_in_t  pinIn,
   output var  tw_pkg::tw_pin_out_t pinOut,
   // software side
   input  wire tw_pkg::tw_cfg_t     cfg,
   input  wire tw_pkg::tw_cmd_t     cmd,
   output var  tw_pkg::tw_stat_t    stat
);
   import tw_pkg::*;

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function automatic logic maskEq(input logic [9:0] rcv, input logic [9:0] own,
                                   input logic [9:0] msk);
      maskEq = ((rcv ^ own) & ~msk) == 10'h000;
   endfunction

   function automatic logic reservedAddr(input logic [6:0] a);
      reservedAddr = (a[6:3] == `TW_RSV_LOW) || (a[6:3] == `TW_RSV_HIGH);
   endfunction

   // -------------------------------------------------------------------
   // link domain: pin sampling and start/stop detection
   // -------------------------------------------------------------------
   tw_link_st_t l_q;
   tw_link_st_t l_d;

   always_comb begin
      l_d      = l_q;
      l_d.sclA = pinIn.scl;
      l_d.sclB = l_q.sclA;
      l_d.sdaA = pinIn.sda;
      l_d.sdaB = l_q.sdaA;
      l_d.sdaP = l_q.sdaB;
      if (l_q.sclB && l_q.sdaP && !l_q.sdaB) begin
         l_d.startTgl = ~l_q.startTgl;
      end
      if (l_q.sclB && !l_q.sdaP && l_q.sdaB) begin
         l_d.stopTgl = ~l_q.stopTgl;
      end
   end

   always_ff @(posedge linkClk or posedge rst) begin
      if (rst) begin
         l_q <= '{sclA: `TW_LINE_IDLE, sclB: `TW_LINE_IDLE, sdaA: `TW_LINE_IDLE,
                  sdaB: `TW_LINE_IDLE, sdaP: `TW_LINE_IDLE, startTgl: 1'b0,
                  stopTgl: 1'b0};
      end else begin
         l_q <= l_d;
      end
   end

   // -------------------------------------------------------------------
   // core domain
   // -------------------------------------------------------------------
   tw_core_st_t q;
   tw_core_st_t d;
   tw_core_st_t rstVal;

   always_comb begin
      rstVal        = '0;
      rstVal.sclM   = `TW_LINE_IDLE;
      rstVal.sclC   = `TW_LINE_IDLE;
      rstVal.sclP   = `TW_LINE_IDLE;
      rstVal.sdaM   = `TW_LINE_IDLE;
      rstVal.sdaC   = `TW_LINE_IDLE;
      rstVal.mScl   = `TW_LINE_IDLE;
      rstVal.mSda   = `TW_LINE_IDLE;
      rstVal.mState = M_IDLE;
      rstVal.sState = S_IDLE;
   end

   logic        sclRise;
   logic        sclFall;
   logic        startEvt;
   logic        stopEvt;
   logic        cntDone;
   logic [15:0] baud;
   logic        drv;
   logic [3:0]  lastBit;
   logic [6:0]  a7;
   logic        match;
   logic        gc;
   logic        rxSet;
   logic [7:0]  rxByte;

   always_comb begin
      d      = q;
      drv    = 1'b1;
      lastBit = 4'h0;
      a7     = q.sShift[7:1];
      match  = 1'b0;
      gc     = 1'b0;
      rxSet  = 1'b0;
      rxByte = q.stat.rxData;
      // crossing: levels through two flops, events as toggles
      d.sclM = l_q.sclB;
      d.sclC = q.sclM;
      d.sclP = q.sclC;
      d.sdaM = l_q.sdaB;
      d.sdaC = q.sdaM;
      d.stA  = l_q.startTgl;
      d.stB  = q.stA;
      d.stC  = q.stB;
      d.spA  = l_q.stopTgl;
      d.spB  = q.spA;
      d.spC  = q.spB;
      sclRise  = q.sclC & ~q.sclP;
      sclFall  = ~q.sclC & q.sclP;
      startEvt = q.stB ^ q.stC;
      stopEvt  = q.spB ^ q.spC;
      baud = (cfg.baudReloadValue < `TW_BAUD_MIN) ? `TW_BAUD_MIN : cfg.baudReloadValue;
      cntDone = (q.cnt == 16'h0000);
      if (!cntDone) begin
         d.cnt = q.cnt - 16'h0001;
      end
      // ---------------- master engine ----------------
      unique case (q.mState)
         M_IDLE: begin
            if (cmd.start && !q.stat.busBusy && !q.mOwn) begin
               d.mState = M_START;
               d.mStep  = 2'h0;
               d.cnt    = baud;
            end else if (q.mOwn && cmd.repStart) begin
               d.mState = M_RSTART;
               d.mStep  = 2'h0;
               d.cnt    = baud;
            end else if (q.mOwn && cmd.stop) begin
               d.mState = M_STOP;
               d.mStep  = 2'h0;
               d.cnt    = baud;
            end else if (q.mOwn && cmd.txWrite) begin
               d.mState = M_BIT;
               d.mMode  = MB_TX;
               d.mShift = cmd.txData;
               d.mBit   = 4'h0;
               d.mStep  = 2'h0;
               d.cnt    = baud;
            end else if (q.mOwn && cmd.rcvEnable) begin
               d.mState = M_BIT;
               d.mMode  = MB_RX;
               d.mBit   = 4'h0;
               d.mStep  = 2'h0;
               d.cnt    = baud;
            end else if (q.mOwn && cmd.ackReq) begin
               d.mState   = M_BIT;
               d.mMode    = MB_ACK;
               d.mAckData = cmd.ackData;
               d.mBit     = 4'h0;
               d.mStep    = 2'h0;
               d.cnt      = baud;
            end
         end
         M_START: begin
            if (cntDone) begin
               if (q.mStep == 2'h0) begin
                  if (!q.sdaC || !q.sclC) begin
                     d.stat.busCollision = 1'b1;
                     d.mState = M_IDLE;
                  end else begin
                     d.mSda  = 1'b0;
                     d.mStep = 2'h1;
                     d.cnt   = baud;
                  end
               end else begin
                  d.mScl   = 1'b0;
                  d.mOwn   = 1'b1;
                  d.mState = M_IDLE;
               end
            end
         end
         M_RSTART: begin
            if (q.mStep == 2'h2 && !q.sclC) begin
               d.cnt = baud;
            end else if (cntDone) begin
               d.cnt   = baud;
               d.mStep = q.mStep + 2'h1;
               unique case (q.mStep)
                  2'h0: d.mSda = 1'b1;
                  2'h1: d.mScl = 1'b1;
                  2'h2: d.mSda = 1'b0;
                  2'h3: begin
                     d.mScl   = 1'b0;
                     d.mState = M_IDLE;
                  end
               endcase
            end
         end
         M_STOP: begin
            if (q.mStep == 2'h1 && q.mScl && !q.sclC) begin
               d.cnt = baud;
            end else if (cntDone) begin
               d.cnt = baud;
               unique case (q.mStep)
                  2'h0: begin
                     d.mSda  = 1'b0;
                     d.mStep = 2'h1;
                  end
                  2'h1: begin
                     d.mScl  = 1'b1;
                     d.mStep = q.mScl ? 2'h2 : 2'h1;
                  end
                  default: begin
                     d.mSda   = 1'b1;
                     d.mOwn   = 1'b0;
                     d.mState = M_IDLE;
                  end
               endcase
            end
         end
         M_BIT: begin
            unique case (q.mMode)
               MB_TX:   drv = (q.mBit < `TW_BYTE_LAST) ? q.mShift[7] : 1'b1;
               MB_ACK:  drv = q.mAckData;
               default: drv = 1'b1;
            endcase
            unique case (q.mMode)
               MB_TX:   lastBit = `TW_BYTE_LAST;
               MB_RX:   lastBit = `TW_RX_LAST;
               default: lastBit = 4'h0;
            endcase
            if (q.mStep == 2'h0) begin
               d.mSda = drv;
               if (cntDone) begin
                  d.mScl  = 1'b1;
                  d.mStep = 2'h1;
                  d.cnt   = baud;
               end
            end else if (!q.sclC) begin
               d.cnt = baud;
            end else if (cntDone) begin
               d.mScl  = 1'b0;
               d.mStep = 2'h0;
               d.cnt   = baud;
               d.mBit  = q.mBit + 4'h1;
               if (q.mMode == MB_TX && q.mBit < `TW_BYTE_LAST) begin
                  d.mShift = {q.mShift[6:0], 1'b0};
                  if (drv && !q.sdaC) begin
                     d.stat.busCollision = 1'b1;
                     d.mOwn   = 1'b0;
                     d.mScl   = 1'b1;
                     d.mSda   = 1'b1;
                     d.mState = M_IDLE;
                  end
               end else if (q.mMode == MB_TX) begin
                  d.stat.ackStat = q.sdaC;
               end else if (q.mMode == MB_RX) begin
                  d.mShift = {q.mShift[6:0], q.sdaC};
                  if (q.mBit == `TW_RX_LAST) begin
                     rxSet  = 1'b1;
                     rxByte = {q.mShift[6:0], q.sdaC};
                  end
               end
               if (q.mBit == lastBit) begin
                  d.mState = M_IDLE;
               end
            end
         end
         default: d.mState = M_IDLE;
      endcase

      // ---------------- slave engine ----------------
      unique case (q.sState)
         S_IDLE: ;
         S_ADDR, S_RX: begin
            if (sclRise && q.sBit < `TW_BYTE_LAST) begin
               d.sShift = {q.sShift[6:0], q.sdaC};
               d.sBit   = q.sBit + 4'h1;
            end else if (sclFall && q.sBit == `TW_BYTE_LAST) begin
               d.sBit = 4'h0;
               if (q.sState == S_RX) begin
                  rxSet   = 1'b1;
                  rxByte  = q.sShift;
                  d.sAckDrv = 1'b1;
                  d.sNextRx = 1'b1;
                  d.sState  = S_ACK;
               end else if (q.sTen2) begin
                  match = cfg.acceptAllAddressEnable ||
                          maskEq({2'b00, q.sShift}, {2'b00, cfg.slaveAddr[7:0]},
                                 {2'b00, cfg.slaveAddressMask[7:0]});
                  d.sTen2 = 1'b0;
                  d.sHiMatch = match;
                  d.stat.tenBitMatch = match;
                  d.sNextRx = 1'b1;
               end else if (cfg.addr10Mode && !cfg.acceptAllAddressEnable) begin
                  match = (q.sShift[7:3] == `TW_TEN_HDR) &&
                          maskEq({q.sShift[2:1], 8'h00}, {cfg.slaveAddr[9:8], 8'h00},
                                 {cfg.slaveAddressMask[9:8], 8'h00}) &&
                          (!q.sShift[0] || q.sHiMatch);
                  d.sTen2   = match && !q.sShift[0];
                  d.sNextRx = !q.sShift[0];
                  d.stat.slaveRead = q.sShift[0];
               end else begin
                  gc = (a7 == `TW_GC_ADDR) && !q.sShift[0] && cfg.generalCallEnable;
                  match = cfg.acceptAllAddressEnable || gc ||
                          (!reservedAddr(a7) &&
                           maskEq({3'h0, a7}, {3'h0, cfg.slaveAddr[6:0]},
                                  {3'h0, cfg.slaveAddressMask[6:0]}));
                  d.stat.gcStat    = gc;
                  d.sNextRx        = !q.sShift[0];
                  d.stat.slaveRead = q.sShift[0];
               end
               if (q.sState == S_ADDR) begin
                  d.sAckDrv = match;
                  d.stat.slaveSelected = match | q.stat.slaveSelected;
                  d.sState  = match ? S_ACK : S_IDLE;
               end
            end
         end
         S_ACK: begin
            if (sclFall) begin
               d.sAckDrv = 1'b0;
               d.sBit    = 4'h0;
               if (q.sTen2) begin
                  d.sState = S_ADDR;
               end else if (q.sNextRx) begin
                  d.sState   = S_RX;
                  d.sStretch = cfg.clockStretchEnable && q.stat.slaveSelected;
               end else begin
                  d.sState   = S_TX;
                  d.sStretch = 1'b1;
               end
            end
         end
         S_TX: begin
            if (sclRise && q.sBit == `TW_BYTE_LAST) begin
               d.sBit   = `TW_ACK_DONE;
               d.sState = q.sdaC ? S_IDLE : S_TX;
            end else if (sclRise) begin
               d.sBit = q.sBit + 4'h1;
            end else if (sclFall && q.sBit == `TW_ACK_DONE) begin
               d.sBit     = 4'h0;
               d.sStretch = 1'b1;
            end else if (sclFall && q.sBit != 4'h0) begin
               d.sTx = {q.sTx[6:0], 1'b1};
            end
         end
         default: d.sState = S_IDLE;
      endcase
      // stretch release: data load when sending, software release when receiving
      if (q.sStretch && q.sState == S_TX && cmd.txWrite && !q.mOwn) begin
         d.sTx      = cmd.txData;
         d.sStretch = 1'b0;
      end else if (q.sStretch && q.sState == S_RX && cmd.sclRelease) begin
         d.sStretch = 1'b0;
      end
      if (stopEvt || startEvt) begin
         d.sState    = startEvt ? S_ADDR : S_IDLE;
         d.sBit      = 4'h0;
         d.sAckDrv   = 1'b0;
         d.sStretch  = 1'b0;
         d.sTen2     = 1'b0;
         d.stat.slaveSelected = 1'b0;
      end
      if (stopEvt) begin
         d.sHiMatch         = 1'b0;
         d.stat.gcStat      = 1'b0;
         d.stat.tenBitMatch = 1'b0;
      end

      // ---------------- status ----------------
      d.stat.startSeen = startEvt ? 1'b1 : (stopEvt ? 1'b0 : q.stat.startSeen);
      d.stat.stopSeen  = stopEvt ? 1'b1 : (startEvt ? 1'b0 : q.stat.stopSeen);
      d.stat.busBusy   = startEvt ? 1'b1 : (stopEvt ? 1'b0 : q.stat.busBusy);
      if (cmd.collClr && !(d.stat.busCollision && !q.stat.busCollision)) begin
         d.stat.busCollision = 1'b0;
      end
      if (cmd.ovfClr) begin
         d.stat.rxOverflow = 1'b0;
      end
      if (cmd.rxRead) begin
         d.stat.rxFull = 1'b0;
      end
      if (rxSet) begin
         d.stat.rxData = rxByte;
         d.stat.rxFull = 1'b1;
         if (q.stat.rxFull && !cmd.rxRead) begin
            d.stat.rxOverflow = 1'b1;
         end
      end
      d.stat.masterBusy    = (d.mState != M_IDLE);
      d.stat.masterOwnsBus = d.mOwn;
      d.stat.clockHeld     = d.sStretch;
      d.pins.sclOut = 1'b0;
      d.pins.sdaOut = 1'b0;
      d.pins.sclOe  = ~d.mScl | d.sStretch;
      d.pins.sdaOe  = ~d.mSda | d.sAckDrv |
                      (d.sState == S_TX && d.sBit < `TW_BYTE_LAST && !d.sStretch &&
                       !d.sTx[7]);
      if (!cfg.enable) begin
         d = rstVal;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '{sclM: 1'b1, sclC: 1'b1, sclP: 1'b1, sdaM: 1'b1, sdaC: 1'b1,
                mState: M_IDLE, mMode: MB_TX, mScl: 1'b1, mSda: 1'b1,
                sState: S_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   assign pinOut = q.pins;
   assign stat   = q.stat;
endmodule
`default_nettype wire

// ==== logic/tw_map.svh ====
// constants of the two-wire master/slave core
// Contract
// - master and slave engines run independently of each other.
// - slave compares 7-bit or 10-bit addresses; master sends any address byte.
// - slave recognises the general call address; the code does so only in 7-bit mode or in accept-all mode, not in 10-bit mode.
// - slave holds the clock low until software is ready.
// - bus clock rate set by reload value covers 100 kHz and 400 kHz.
// - master follows clock synchronisation and detects lost arbitration.
// - accept-all mode makes the slave take every address.
// - start request drives a Start condition.
// - master sends address byte, then samples and reports the acknowledge.
// - each data byte is sent and its acknowledge sampled.
// - repeated start request re-addresses without a Stop.
// - receive enable clocks in one byte from the slave.
// - after a received byte the master drives ACK or NACK as chosen.
// - stop request drives a Stop condition and releases the bus.
// - each mask bit makes its address bit don't-care, both modes.
// - a masked position matches a received 0 or 1.
// - in 7-bit mode reserved addresses never match the own address, whatever the mask.
// - general call acknowledged only while general call enable is 1, or in accept-all mode.
// - accept-all mode acknowledges every address.
`ifndef TW_MAP_SVH
`define TW_MAP_SVH
`define TW_BAUD_MIN      16'h0002
`define TW_LINE_IDLE     1'b1
`define TW_BYTE_LAST     4'h8
`define TW_RX_LAST       4'h7
`define TW_ACK_DONE      4'h9
`define TW_GC_ADDR       7'h00
`define TW_TEN_HDR       5'h1E
`define TW_RSV_LOW       4'h0
`define TW_RSV_HIGH      4'hF
`endif

// ==== logic/tw_pkg.sv ====
// types of the two-wire master/slave core
package tw_pkg;
   typedef enum logic [2:0] {M_IDLE = 3'h0, M_START = 3'h1, M_RSTART = 3'h2,
                             M_STOP = 3'h3, M_BIT = 3'h4} tw_mstate_t;
   typedef enum logic [1:0] {MB_TX = 2'h0, MB_RX = 2'h1, MB_ACK = 2'h2} tw_mmode_t;
   typedef enum logic [2:0] {S_IDLE = 3'h0, S_ADDR = 3'h1, S_ACK = 3'h2,
                             S_RX = 3'h3, S_TX = 3'h4} tw_sstate_t;
   typedef struct packed {logic scl; logic sda;} tw_pin_in_t;
   typedef struct packed {logic sclOut; logic sclOe; logic sdaOut; logic sdaOe;} tw_pin_out_t;
   typedef struct packed {
      logic enable; logic addr10Mode; logic acceptAllAddressEnable;
      logic generalCallEnable; logic clockStretchEnable;
      logic [9:0] slaveAddr; logic [9:0] slaveAddressMask; logic [15:0] baudReloadValue;
   } tw_cfg_t;
   typedef struct packed {
      logic start; logic repStart; logic stop; logic rcvEnable; logic ackReq;
      logic ackData; logic txWrite; logic [7:0] txData; logic rxRead;
      logic sclRelease; logic collClr; logic ovfClr;
   } tw_cmd_t;
   typedef struct packed {
      logic masterBusy; logic masterOwnsBus; logic ackStat; logic busCollision;
      logic busBusy; logic startSeen; logic stopSeen; logic slaveSelected;
      logic slaveRead; logic gcStat; logic tenBitMatch; logic clockHeld;
      logic rxFull; logic rxOverflow; logic [7:0] rxData;
   } tw_stat_t;
   typedef struct packed {
      logic sclA; logic sclB; logic sdaA; logic sdaB; logic sdaP;
      logic startTgl; logic stopTgl;
   } tw_link_st_t;
   typedef struct packed {
      logic sclM; logic sclC; logic sclP; logic sdaM; logic sdaC;
      logic stA; logic stB; logic stC; logic spA; logic spB; logic spC;
      tw_mstate_t mState; logic [1:0] mStep; tw_mmode_t mMode; logic [3:0] mBit;
      logic [7:0] mShift; logic mAckData; logic [15:0] cnt; logic mScl; logic mSda;
      logic mOwn;
      tw_sstate_t sState; logic [3:0] sBit; logic [7:0] sShift; logic [7:0] sTx;
      logic sAckDrv; logic sStretch; logic sTen2; logic sHiMatch; logic sNextRx;
      tw_pin_out_t pins; tw_stat_t stat;
   } tw_core_st_t;
endpackage

// ==== verif/testbench.sv ====
// testbench: two-wire core as master, its own slave and a memory peer on one bus
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tw_pkg::*;
   // f holds ten, all, gc, nack, selected
   typedef struct {logic [7:0] a; logic [7:0] b; logic [4:0] f; logic [9:0] sa, mk;} tw_row_t;
   logic        core_clk = 1'b0;
   logic        linkClk = 1'b0;
   logic        rst = 1'b1;
   logic        pSclOe;
   logic        pSdaOe;
   tw_pin_in_t  pinIn;
   tw_pin_out_t pinOut;
   tw_cfg_t     cfg;
   tw_cmd_t     cmd;
   tw_stat_t    stat;
   int          error_cnt = 0;
   int          total_checks = 0;
   int          cyc = 0;
   wire logic   sclW = ~(pinOut.sclOe | pSclOe);
   wire logic   sdaW = ~(pinOut.sdaOe | pSdaOe);
   tw_row_t rows [12] = '{
      '{8'hA0, 8'h00, 5'h00, 10'h011, 10'h000}, '{8'h90, 8'h00, 5'h02, 10'h011, 10'h000},
      '{8'h22, 8'h00, 5'h01, 10'h011, 10'h000}, '{8'h26, 8'h00, 5'h01, 10'h011, 10'h002},
      '{8'h26, 8'h00, 5'h02, 10'h011, 10'h000}, '{8'h00, 8'h00, 5'h05, 10'h011, 10'h000},
      '{8'h00, 8'h00, 5'h02, 10'h011, 10'h000}, '{8'h08, 8'h00, 5'h02, 10'h004, 10'h000},
      '{8'h02, 8'h00, 5'h02, 10'h011, 10'h07F}, '{8'h66, 8'h00, 5'h09, 10'h011, 10'h000},
      '{8'hF4, 8'hA5, 5'h11, 10'h2A5, 10'h000}, '{8'hF4, 8'hA4, 5'h11, 10'h2A5, 10'h001}};
   assign pinIn = {sclW, sdaW};
   always #2.5 core_clk = ~core_clk;
   always begin
      #1.3;
      forever #3 linkClk = ~linkClk;
   end
   tw_core tw_core_inst (.core_clk(core_clk), .rst(rst), .linkClk(linkClk), .pinIn(pinIn),
      .pinOut(pinOut), .cfg(cfg), .cmd(cmd), .stat(stat));
   tw_peer #(.STRETCH(300)) tw_peer_inst (.scl(sclW), .sda(sdaW), .sclOe(pSclOe), .sdaOe(pSdaOe));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one command pulse, then wait for the master to go idle
   task automatic op(input int k, input logic [7:0] d);
      int      n;
      tw_cmd_t c;
      c = '0;
      c.start = k == 0;
      c.repStart = k == 1;
      c.stop = k == 2;
      c.txWrite = k == 3;
      c.rcvEnable = k == 4;
      c.ackReq = k == 5;
      c.rxRead = k == 6;
      c.sclRelease = k == 7;
      c.txData = d;
      c.ackData = d[0];
      cmd = c;
      @(negedge core_clk);
      cmd = '0;
      @(negedge core_clk);
      n = 0;
      while (stat.masterBusy !== 1'b0 && n < 4000) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 4000) chk(8'h01, 8'h00);
      if (k == 2) repeat (30) @(negedge core_clk);
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim;
      end
   end
   // ----------------------------------------
   // address table, then a full write and read
   // ----------------------------------------
   initial begin
      cmd = '0;
      cfg = '0;
      cfg.enable = 1'b1;
      cfg.baudReloadValue = 16'h0009;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      chk(8'(stat === '0), 8'h01);
      chk({6'h00, pinOut.sclOe, pinOut.sdaOe}, 8'h00);
      foreach (rows[i]) begin
         cfg.addr10Mode = rows[i].f[4];
         cfg.acceptAllAddressEnable = rows[i].f[3];
         cfg.generalCallEnable = rows[i].f[2];
         cfg.slaveAddr = rows[i].sa;
         cfg.slaveAddressMask = rows[i].mk;
         op(0, 8'h00);
         op(3, rows[i].a);
         if (rows[i].f[4]) op(3, rows[i].b);
         chk(8'(stat.ackStat), 8'(rows[i].f[1]));
         chk(8'(stat.slaveSelected), 8'(rows[i].f[0]));
         chk(8'({stat.gcStat, stat.tenBitMatch}), 8'({rows[i].f[2], rows[i].f[4]}));
         op(2, 8'h00);
      end
      cfg.addr10Mode = 1'b0;
      cfg.clockStretchEnable = 1'b1;
      op(0, 8'h00);
      op(3, 8'h4A);
      repeat (9) @(negedge core_clk);
      chk(8'(stat.clockHeld), 8'h01);
      op(7, 8'h00);
      chk(8'(stat.clockHeld), 8'h00);
      op(2, 8'h00);
      op(0, 8'h00);
      op(3, 8'hA0);
      op(3, 8'h3C);
      chk(8'(stat.ackStat), 8'h00);
      op(1, 8'h00);
      op(3, 8'hA1);
      chk(8'(stat.ackStat), 8'h00);
      op(4, 8'h00);
      chk(stat.rxData, 8'hC5);
      chk(8'(stat.rxFull), 8'h01);
      op(6, 8'h00);
      chk(8'(stat.rxFull), 8'h00);
      op(5, 8'h01);
      op(2, 8'h00);
      chk(8'(stat.masterOwnsBus), 8'h00);
      chk(tw_peer_inst.lastWr, 8'h3C);
      end_sim;
   end
endmodule
bind tw_core tw_core_chk tw_core_chk_inst (.core_clk(core_clk), .rst(rst), .pinOut(pinOut),
   .cfg(cfg), .cmd(cmd), .stat(stat));
`default_nettype wire

// ==== verif/tw_core_chk.sv ====
// port checker for the two-wire core
`timescale 1ns/1ps
`default_nettype none
module tw_core_chk (
   // clock and reset
   input wire logic                core_clk,
   input wire logic                rst,
   // pins and software side
   input wire tw_pkg::tw_pin_out_t pinOut,
   input wire tw_pkg::tw_cfg_t     cfg,
   input wire tw_pkg::tw_cmd_t     cmd,
   input wire tw_pkg::tw_stat_t    stat
);
   import tw_pkg::*;
   logic [16:0] eff;
   logic [16:0] stCnt_q;
   logic [16:0] lowCnt_q;
   logic        ackBit_q;
   // ----------------------------------------
   // half-bit counters
   // ----------------------------------------
   assign eff = (cfg.baudReloadValue < 16'h0002) ? 17'h00002 : {1'b0, cfg.baudReloadValue};
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stCnt_q <= '0;
         lowCnt_q <= '0;
         ackBit_q <= 1'b0;
      end else begin
         stCnt_q <= (pinOut.sdaOe && !pinOut.sclOe && !stat.masterOwnsBus) ? stCnt_q + 17'h1 : '0;
         lowCnt_q <= pinOut.sclOe ? lowCnt_q + 17'h1 : '0;
         if (cmd.ackReq) begin
            ackBit_q <= cmd.ackData;
         end
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_start_taken: assert property (
      cfg.enable && cmd.start && !stat.masterBusy && !stat.busBusy && !stat.masterOwnsBus
      |-> ##[1:2] stat.masterBusy) else $error("start request not taken");
   a_start_shape: assert property (
      $rose(stat.masterOwnsBus) |-> pinOut.sdaOe && pinOut.sclOe && stCnt_q == eff + 17'h1)
      else $error("start condition malformed");
   a_low_half: assert property (
      $fell(pinOut.sclOe) && stat.masterBusy |-> lowCnt_q >= eff + 17'h1)
      else $error("clock low half too short");
   a_open_drain: assert property (!pinOut.sclOut && !pinOut.sdaOut)
      else $error("pin driven high");
   a_stop_release: assert property (
      $fell(stat.masterOwnsBus) && !stat.busCollision |-> !pinOut.sclOe && !pinOut.sdaOe)
      else $error("bus not released");
   a_stop_done: assert property (
      cmd.stop && !stat.masterBusy && stat.masterOwnsBus |-> ##[2:1000] !stat.masterOwnsBus)
      else $error("stop never completed");
   a_ack_drive: assert property (
      cmd.ackReq && !stat.masterBusy && stat.masterOwnsBus
      |=> ##[1:20] (!pinOut.sclOe && pinOut.sdaOe == !ackBit_q)) else $error("ack bit wrong");
   a_rx_done: assert property (
      cmd.rcvEnable && !stat.masterBusy && stat.masterOwnsBus
      |-> ##[16:1000] (stat.rxFull && !stat.masterBusy)) else $error("receive never done");
   a_tx_busy: assert property (
      cmd.txWrite && !stat.masterBusy && stat.masterOwnsBus
      |-> ##[1:2] stat.masterBusy ##[1:1000] !stat.masterBusy) else $error("byte never sent");
   c_rx: cover property ($rose(stat.rxFull));
   c_sel: cover property ($rose(stat.slaveSelected));
   c_nack: cover property ($rose(stat.ackStat));
endmodule
`default_nettype wire

// ==== verif/tw_peer.sv ====
// serial memory peer: acks its address, keeps the last written byte, returns one byte
`timescale 1ns/1ps
`default_nettype none
module tw_peer #(
   parameter logic [6:0] ADDR    = 7'h50,
   parameter logic [7:0] RDATA   = 8'hC5,
   parameter int         STRETCH = 0
) (
   // bus wires
   input  wire logic scl,
   input  wire logic sda,
   // pull-downs
   output var  logic sclOe = 1'b0,
   output var  logic sdaOe = 1'b0
);
   logic [7:0] lastWr = 8'h00;
   // ev flags a start or stop seen while the clock is high
   task automatic getBit(output logic b, output logic ev);
      ev = 1'b0;
      @(posedge scl);
      b = sda;
      while (scl === 1'b1) begin
         @(sda or scl);
         if (scl === 1'b1) ev = 1'b1;
      end
   endtask
   task automatic rxByte(output logic [7:0] d, output logic ev);
      logic b;
      ev = 1'b0;
      for (int i = 0; i < 8 && !ev; i++) begin
         getBit(b, ev);
         d = {d[6:0], b};
      end
   endtask
   always begin : sess
      logic [7:0] d;
      logic       ev, b, me, rd, first;
      @(negedge sda iff scl === 1'b1);
      first = 1'b1;
      me = 1'b0;
      rd = 1'b0;
      ev = 1'b0;
      while (!(ev && sda === 1'b1)) begin
         if (me && rd && !first) begin
            for (int i = 7; i >= 0; i--) begin
               sdaOe = ~RDATA[i];
               @(negedge scl);
            end
            sdaOe = 1'b0;
            getBit(b, ev);
            me = ~b;
         end else begin
            rxByte(d, ev);
            if (ev) begin
               first = 1'b1;
               me = 1'b0;
            end else if (first || me) begin
               if (first) begin
                  me = d[7:1] == ADDR;
                  rd = d[0];
               end else begin
                  lastWr = d;
               end
               if (me) begin
                  sdaOe = 1'b1;
                  getBit(b, ev);
                  sdaOe = rd & ~RDATA[7];
                  if (rd) begin
                     sclOe = 1'b1;
                     #STRETCH;
                     sclOe = 1'b0;
                  end
               end
               first = 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire
